//--- src/asr_map.svh
// Constants for the converter control and serial readout block
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
// ----------------------------------------
// Timing in nanoseconds
// ----------------------------------------
`define ASR_CLK_NS 50
`define ASR_CONV_NS 3800
`define ASR_EFF_SLEEP_NS 9800
`define ASR_HOLD_NS 10
// ----------------------------------------
// Timing in clock cycles
// ----------------------------------------
`define ASR_CONV_CYC ((`ASR_CONV_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_WAKE_CYC ((`ASR_EFF_SLEEP_NS - `ASR_CONV_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_HOLD_CYC ((`ASR_HOLD_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define ASR_RES_BITS 12
`define ASR_FRAME_BITS 16
`define ASR_LAST_BIT 15
`define ASR_RES_MSB 11
`define ASR_LEAD_ZEROS 4'h0
`endif

//--- src/asr_pkg.sv
// Types for the converter control and serial readout block
package asr_pkg;
	typedef enum logic [3:0] {
		ASR_IDLE = 4'h1,
		ASR_CONV = 4'h2,
		ASR_SLEEP = 4'h4,
		ASR_WAKE = 4'h8
	} asr_state_t;
endpackage : asr_pkg

//--- src/asr_sync.sv
// Two-flop synchroniser with edge detection
`timescale 1ns/100ps
module asr_sync #(
	parameter logic IDLE_LEVEL = 1'b1
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			meta_reg <= IDLE_LEVEL;
			sync_reg <= IDLE_LEVEL;
			last_reg <= IDLE_LEVEL;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end
	always_comb begin
		level_out = sync_reg;
		rise_out = sync_reg & ~last_reg;
		fall_out = ~sync_reg & last_reg;
	end
endmodule : asr_sync

//--- src/asr_top.sv
// Converter control, auto power-down and serial result frame
`timescale 1ns/100ps
`include "asr_map.svh"
// What this block and its host do
// RULE1: Each serial clock falling edge presents the next frame bit.
// RULE2: Host may capture a bit on the same falling edge that advances it.
// RULE3: Host leaves serial clock low once the frame has finished.
// RULE4: Frame is sixteen bits: four leading zeros, then twelve result bits.
// RULE5: After the sixteenth falling edge, hold last bit, then release output.
// RULE6: Two's complement for bipolar ranges, straight binary for unipolar.
// RULE7: Busy rises on convert-start falling edge, falls when conversion completes.
// RULE8: Convert-start falling edge puts track/hold into hold, starts conversion.
// RULE9: Conversion ending with convert-start still low enters power-down.
// RULE10: Powered down, the convert-start rising edge begins wake-up.
// RULE11: Conversion 3.8 us normally, effectively 9.8 us including wake-up.
// RULE12: Host avoids reading during conversion and 300 ns before next.
// RULE13: Host starts clocking the frame only after busy returns low.
module asr_top (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic convert_start_n_in,
	input wire logic serial_clock_in,
	input wire logic [11:0] sample_code_in,
	input wire logic bipolar_in,
	output logic busy_out,
	output logic track_hold_out,
	output logic power_down_out,
	output logic serial_result_out,
	output logic serial_result_oe_out
);
	localparam logic [7:0] CONV_CYC = 8'(`ASR_CONV_CYC);
	localparam logic [7:0] WAKE_CYC = 8'(`ASR_WAKE_CYC);
	localparam logic [7:0] HOLD_CYC = 8'(`ASR_HOLD_CYC);
	localparam logic [4:0] LAST_BIT = 5'(`ASR_LAST_BIT);

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic cs_lvl;
	logic cs_rise;
	logic cs_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic conv_done;
	asr_pkg::asr_state_t state_reg;
	asr_pkg::asr_state_t state_next;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic busy_reg;
	logic busy_next;
	logic track_hold_reg;
	logic track_hold_next;
	logic power_down_reg;
	logic power_down_next;
	logic pending_reg;
	logic pending_next;
	logic [15:0] frame_reg;
	logic [15:0] frame_next;
	logic ready_reg;
	logic ready_next;
	logic active_reg;
	logic active_next;
	logic [15:0] shift_reg;
	logic [15:0] shift_next;
	logic [4:0] bit_cnt_reg;
	logic [4:0] bit_cnt_next;
	logic [7:0] hold_cnt_reg;
	logic [7:0] hold_cnt_next;
	logic serial_result_reg;
	logic serial_result_next;
	logic serial_result_oe_reg;
	logic serial_result_oe_next;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [7:0] count_down(input logic [7:0] value);
		return (value == 8'h00) ? 8'h00 : value - 8'h01;
	endfunction : count_down

	function automatic logic [15:0] code_word(input logic [11:0] code, input logic bipolar);
		logic [11:0] coded;
		coded = bipolar ? {~code[`ASR_RES_MSB], code[10:0]} : code; // RULE6
		return {`ASR_LEAD_ZEROS, coded}; // RULE4
	endfunction : code_word

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	asr_sync #(
		.IDLE_LEVEL(1'b1)
	) u_convert_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in(convert_start_n_in),
		.level_out(cs_lvl),
		.rise_out(cs_rise),
		.fall_out(cs_fall)
	);

	asr_sync #(
		.IDLE_LEVEL(1'b0)
	) u_sclk_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in(serial_clock_in),
		.level_out(),
		.rise_out(sclk_rise),
		.fall_out(sclk_fall)
	);

	// ----------------------------------------
	// Conversion control
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		count_next = count_down(count_reg);
		busy_next = busy_reg;
		track_hold_next = track_hold_reg;
		power_down_next = power_down_reg;
		pending_next = pending_reg;
		conv_done = 1'b0;
		unique case (state_reg)
			asr_pkg::ASR_IDLE: begin
				if (cs_fall) begin // RULE8
					state_next = asr_pkg::ASR_CONV;
					count_next = CONV_CYC; // RULE11
					busy_next = 1'b1; // RULE7
					track_hold_next = 1'b1; // RULE8
				end
			end
			asr_pkg::ASR_CONV: begin
				if (count_reg == 8'h01) begin
					conv_done = 1'b1;
					busy_next = 1'b0; // RULE7
					track_hold_next = 1'b0;
					if (!cs_lvl) begin // RULE9
						state_next = asr_pkg::ASR_SLEEP;
						power_down_next = 1'b1;
					end else begin
						state_next = asr_pkg::ASR_IDLE;
					end
				end
			end
			asr_pkg::ASR_SLEEP: begin
				if (cs_rise) begin // RULE10
					state_next = asr_pkg::ASR_WAKE;
					count_next = WAKE_CYC; // RULE11
					power_down_next = 1'b0;
				end
			end
			asr_pkg::ASR_WAKE: begin
				if (cs_fall) begin // RULE8
					busy_next = 1'b1; // RULE7
					track_hold_next = 1'b1;
					pending_next = 1'b1;
				end
				if (count_reg == 8'h01) begin // RULE11
					if (pending_reg || cs_fall) begin
						state_next = asr_pkg::ASR_CONV;
						count_next = CONV_CYC;
						pending_next = 1'b0;
					end else begin
						state_next = asr_pkg::ASR_IDLE;
					end
				end
			end
			default: begin
				state_next = asr_pkg::ASR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= asr_pkg::ASR_IDLE;
			count_reg <= 8'h00;
			busy_reg <= 1'b0;
			track_hold_reg <= 1'b0;
			power_down_reg <= 1'b0;
			pending_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			busy_reg <= busy_next;
			track_hold_reg <= track_hold_next;
			power_down_reg <= power_down_next;
			pending_reg <= pending_next;
		end
	end

	// ----------------------------------------
	// Serial result frame
	// ----------------------------------------
	// Code and range select come from converter logic on this clock
	always_comb begin
		frame_next = frame_reg;
		ready_next = ready_reg;
		active_next = active_reg;
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		hold_cnt_next = count_down(hold_cnt_reg);
		serial_result_next = serial_result_reg;
		serial_result_oe_next = serial_result_oe_reg;
		if (conv_done) begin
			frame_next = code_word(sample_code_in, bipolar_in); // RULE4
			ready_next = 1'b1;
		end
		if (hold_cnt_reg == 8'h01) begin // RULE5
			serial_result_oe_next = 1'b0;
			serial_result_next = 1'b0;
		end
		if (active_reg) begin
			if (sclk_fall) begin // RULE1
				if (bit_cnt_reg == LAST_BIT) begin
					active_next = 1'b0;
					hold_cnt_next = HOLD_CYC; // RULE5
				end else begin
					shift_next = shift_reg << 1;
					serial_result_next = shift_reg[14]; // RULE1
					bit_cnt_next = bit_cnt_reg + 5'h01;
				end
			end
		end else if (sclk_rise && ready_reg && hold_cnt_reg == 8'h00) begin
			active_next = 1'b1;
			ready_next = conv_done;
			shift_next = frame_reg;
			bit_cnt_next = 5'h00;
			serial_result_next = frame_reg[15];
			serial_result_oe_next = 1'b1;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			frame_reg <= 16'h0000;
			ready_reg <= 1'b0;
			active_reg <= 1'b0;
			shift_reg <= 16'h0000;
			bit_cnt_reg <= 5'h00;
			hold_cnt_reg <= 8'h00;
			serial_result_reg <= 1'b0;
			serial_result_oe_reg <= 1'b0;
		end else begin
			frame_reg <= frame_next;
			ready_reg <= ready_next;
			active_reg <= active_next;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			hold_cnt_reg <= hold_cnt_next;
			serial_result_reg <= serial_result_next;
			serial_result_oe_reg <= serial_result_oe_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign busy_out = busy_reg;
	assign track_hold_out = track_hold_reg;
	assign power_down_out = power_down_reg;
	assign serial_result_out = serial_result_reg;
	assign serial_result_oe_out = serial_result_oe_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_busy_on_start;
		@(posedge clock_in) disable iff (rst_in)
		(state_reg == asr_pkg::ASR_IDLE && cs_fall) |=> busy_reg;
	endproperty
	a_busy_on_start: assert property (p_busy_on_start) // RULE7
		else $error("busy not raised on convert start");

	property p_hold_in_conv;
		@(posedge clock_in) disable iff (rst_in)
		(state_reg == asr_pkg::ASR_CONV) |-> track_hold_reg;
	endproperty
	a_hold_in_conv: assert property (p_hold_in_conv) // RULE8
		else $error("track/hold not in hold during conversion");

	property p_sleep_entry;
		@(posedge clock_in) disable iff (rst_in)
		(conv_done && !cs_lvl) |=> (power_down_reg && !busy_reg);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) // RULE9
		else $error("no power-down after conversion with start low");

	property p_wake_on_rise;
		@(posedge clock_in) disable iff (rst_in)
		(state_reg == asr_pkg::ASR_SLEEP && cs_rise) |=> !power_down_reg;
	endproperty
	a_wake_on_rise: assert property (p_wake_on_rise) // RULE10
		else $error("no wake-up on convert start rising edge");

	property p_conv_length;
		@(posedge clock_in) disable iff (rst_in)
		$rose(state_reg == asr_pkg::ASR_CONV) |-> (count_reg == CONV_CYC);
	endproperty
	a_conv_length: assert property (p_conv_length) // RULE11
		else $error("conversion count not loaded");

	property p_lead_zero;
		@(posedge clock_in) disable iff (rst_in)
		$rose(serial_result_oe_reg) |-> !serial_result_reg;
	endproperty
	a_lead_zero: assert property (p_lead_zero) // RULE4
		else $error("frame does not open with a zero");

	property p_shift_on_fall;
		@(posedge clock_in) disable iff (rst_in)
		(active_reg && sclk_fall && bit_cnt_reg != LAST_BIT) |=>
			(serial_result_reg == $past(shift_reg[14]));
	endproperty
	a_shift_on_fall: assert property (p_shift_on_fall) // RULE1
		else $error("next bit not presented on falling edge");

	property p_release;
		@(posedge clock_in) disable iff (rst_in)
		(active_reg && sclk_fall && bit_cnt_reg == LAST_BIT) |=>
			serial_result_oe_reg ##1 !serial_result_oe_reg;
	endproperty
	a_release: assert property (p_release) // RULE5
		else $error("output not held then released after last bit");

	c_normal_conv: cover property (@(posedge clock_in) disable iff (rst_in) conv_done && cs_lvl);
	c_sleep_conv: cover property (@(posedge clock_in) disable iff (rst_in) conv_done && !cs_lvl);
	c_wake_start: cover property (@(posedge clock_in) disable iff (rst_in)
		state_reg == asr_pkg::ASR_WAKE && cs_fall);
	c_frame_end: cover property (@(posedge clock_in) disable iff (rst_in)
		active_reg && sclk_fall && bit_cnt_reg == LAST_BIT);
endmodule : asr_top

//--- bench/asr_host_model.sv
// Host model clocking out one result frame
`timescale 1ns/100ps
module asr_host_model (
	input wire logic clock_in,
	input wire logic data_in,
	output logic serial_clock_out
);
	initial serial_clock_out = 1'b0;
	task automatic read_frame(output logic [15:0] frame);
		frame = 16'h0000;
		for (int i = 0; i < 128; i++) begin
			@(posedge clock_in);
			if (i % 4 == 3) begin
				serial_clock_out <= ~serial_clock_out;
				if (serial_clock_out) frame = {frame[14:0], data_in};
			end
		end
	endtask : read_frame
endmodule : asr_host_model

//--- bench/asr_tb_top.sv
// Bench for the converter control block
`timescale 1ns/100ps
`include "asr_map.svh"
module adc_serial_readout_control_tb_top;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic cs_n = 1'b1;
	logic bipolar = 1'b1;
	logic sclk;
	logic dout;
	logic oe;
	logic busy;
	logic pd;
	logic th;
	logic [15:0] frame;
	int num_errors = 0;
	int compares = 0;
	always #25 clock_in = ~clock_in;
	asr_host_model host (.clock_in(clock_in), .data_in(dout), .serial_clock_out(sclk));
	asr_top dut (.clock_in(clock_in), .rst_in(rst_in), .convert_start_n_in(cs_n),
		.serial_clock_in(sclk), .sample_code_in(12'hA5C), .bipolar_in(bipolar),
		.busy_out(busy), .track_hold_out(th), .power_down_out(pd),
		.serial_result_out(dout), .serial_result_oe_out(oe));
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: word got %h expected %h", $time, got, exp);
		end
	endtask : check_word
	task automatic check_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: bit got %b expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic summarize;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	task automatic wait_busy(input logic lvl);
		for (int i = 0; i < 400 && busy !== lvl; i++) @(posedge clock_in);
		check_bit(busy, lvl);
		if (busy !== lvl) summarize();
	endtask : wait_busy
	task automatic convert(input logic hold_low, input logic bip, input logic [15:0] exp);
		@(posedge clock_in);
		cs_n <= 1'b0;
		bipolar <= bip;
		wait_busy(1'b1);
		check_bit(th, 1'b1);
		if (!hold_low) begin
			@(posedge clock_in);
			cs_n <= 1'b1;
		end
		wait_busy(1'b0);
		repeat (2) @(posedge clock_in);
		check_bit(pd, hold_low);
		check_bit(th, 1'b0);
		cs_n <= 1'b1;
		repeat (5) @(posedge clock_in);
		check_bit(pd, 1'b0);
		host.read_frame(frame);
		check_word(frame, exp);
		repeat (8) @(posedge clock_in);
		check_bit(oe, 1'b0);
	endtask : convert
	task automatic wake_convert;
		int n;
		@(posedge clock_in);
		cs_n <= 1'b0;
		bipolar <= 1'b0;
		wait_busy(1'b1);
		wait_busy(1'b0);
		repeat (2) @(posedge clock_in);
		check_bit(pd, 1'b1);
		cs_n <= 1'b1;
		repeat (2) @(posedge clock_in);
		cs_n <= 1'b0;
		repeat (2) @(posedge clock_in);
		cs_n <= 1'b1;
		n = 4;
		for (int i = 0; i < 400 && busy !== 1'b1; i++) begin
			@(posedge clock_in);
			n++;
		end
		for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
			@(posedge clock_in);
			n++;
		end
		check_bit(n >= `ASR_WAKE_CYC + `ASR_CONV_CYC && n <= `ASR_WAKE_CYC + `ASR_CONV_CYC + 4,
			1'b1);
		repeat (2) @(posedge clock_in);
		check_bit(pd, 1'b0);
		host.read_frame(frame);
		check_word(frame, 16'h0A5C);
		repeat (8) @(posedge clock_in);
		check_bit(oe, 1'b0);
	endtask : wake_convert
	task automatic reset_check;
		@(posedge clock_in);
		cs_n <= 1'b0;
		wait_busy(1'b1);
		rst_in <= 1'b1;
		cs_n <= 1'b1;
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		check_bit(busy | pd | oe | th, 1'b0);
		repeat (4) @(posedge clock_in);
		check_bit(busy, 1'b0);
	endtask : reset_check
	initial begin
		repeat (8) @(posedge clock_in);
		rst_in <= 1'b0;
		convert(1'b0, 1'b1, 16'h025C);
		convert(1'b0, 1'b0, 16'h0A5C);
		convert(1'b1, 1'b1, 16'h025C);
		wake_convert();
		reset_check();
		convert(1'b0, 1'b1, 16'h025C);
		summarize();
	end
endmodule : adc_serial_readout_control_tb_top
